// ---- hdl/pisr_map.vh ----
/*
 * Register map constants for the proximity interrupt status and modulator timing bank.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PISR_MAP_VH
`define PISR_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define PISR_ADDR_IRQ_CTRL 8'h89
`define PISR_ADDR_LOW_HI 8'h8a
`define PISR_ADDR_LOW_LO 8'h8b
`define PISR_ADDR_HIGH_HI 8'h8c
`define PISR_ADDR_HIGH_LO 8'h8d
`define PISR_ADDR_FLAGS 8'h8e
`define PISR_ADDR_MOD 8'h8f
`define PISR_ADDR_AMBIENT 8'h90
// ****************************************
// Field positions
// ****************************************
`define PISR_BIT_ABOVE 0
`define PISR_BIT_BELOW 1
`define PISR_BIT_READY 3
`define PISR_CTRL_LIMIT_EN 1
`define PISR_CTRL_READY_EN 3
`define PISR_CTRL_CNT_LSB 5
`define PISR_CTRL_CNT_MSB 7
`define PISR_MOD_DELAY_LSB 5
`define PISR_MOD_DELAY_MSB 7
`define PISR_MOD_FREQ_LSB 3
`define PISR_MOD_FREQ_MSB 4
`define PISR_MOD_DEAD_LSB 0
`define PISR_MOD_DEAD_MSB 2
// ****************************************
// Reset values and status flag mask
// ****************************************
`define PISR_RST_MOD 8'h01
`define PISR_RST_CTRL 8'h00
`define PISR_RST_THR 16'h0000
`define PISR_RST_FLAGS 8'h00
`define PISR_FLAG_MASK 8'h0b
`endif

// ---- hdl/pisr_streak.v ----
/*
 * Consecutive-measurement streak counter for one threshold direction.
 * Assumes measStrobe is a one-cycle pulse per new proximity result.
 */
`timescale 1ns/1ps
module pisr_streak (
    input wire clk_sys,
    input wire sys_rst,
    input wire measStrobe,
    input wire beyond,
    input wire [2:0] countSel,
    output wire hit
);
    reg [7:0] runCnt_q;
    reg [7:0] runCnt_d;
    wire [7:0] need;
    // ****************************************
    // Streak count
    // ****************************************
    // A code of n asks for 2**n results in a row beyond the threshold.
    assign need = 8'h01 << countSel;
    // The streak restarts after each firing so a long excursion fires once per streak.
    assign hit = measStrobe && beyond && ((runCnt_q + 8'h01) >= need);
    always @* begin
        runCnt_d = runCnt_q;
        if (measStrobe) begin
            if (!beyond || hit) begin
                runCnt_d = 8'h00;
            end else begin
                runCnt_d = runCnt_q + 8'h01;
            end
        end
    end
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            runCnt_q <= 8'h00;
        end else begin
            runCnt_q <= runCnt_d;
        end
    end
endmodule // pisr_streak

// ---- hdl/pisr_regs.v ----
/*
 * Interrupt status, threshold, interrupt control and modulator timing registers,
 * with the open-drain interrupt pin and one consecutive-result streak counter per threshold.
 * Assumes a byte-wide register port decoded from the serial bus: one-cycle write
 * strobe with address and data, and a combinational read address with a registered
 * read data answer one cycle later. Measurement results arrive with a one-cycle strobe.
 * Assumes a pull-up outside on the interrupt pin, which the pad buffer only ever pulls low.
 * Assumes the emitter and receiver timing logic elsewhere takes the modulator fields as
 * plain settings, with no handshake when they change.
 * Assumes proxResult holds still while measStrobe is high, the only cycle it is looked at.
 */
`timescale 1ns/1ps
`include "pisr_map.vh"
module pisr_regs (
    input wire clk_sys,
    input wire sys_rst,
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire measStrobe,
    input wire [15:0] proxResult,
    output wire intPinIn,
    output wire intPinOut,
    output wire intPinOe,
    output wire [2:0] modDelay,
    output wire [1:0] modFreq,
    output wire [2:0] modDeadTime
);
    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [7:0] irqCtrl_q;
    reg [7:0] modTiming_q;
    reg [15:0] lowThr_q;
    reg [15:0] highThr_q;
    reg [7:0] readMux;
    reg [7:0] setMask;
    reg pinLow_q;
    wire [1:0] limitHit;
    wire [1:0] beyond;
    wire [7:0] clearMask;
    wire limitIrqEnable;
    wire readyIrqEnable;
    wire readySet;
    wire belowSet;
    wire aboveSet;
    wire wrCtrl;
    wire wrLowHi;
    wire wrLowLo;
    wire wrHighHi;
    wire wrHighLo;
    wire wrFlags;
    wire wrMod;
    // ****************************************
    // Write decode
    // ****************************************
    // The ambient location has no decode, so a stray write there is dropped.
    assign wrCtrl = regWrite && (regAddr == `PISR_ADDR_IRQ_CTRL);
    assign wrLowHi = regWrite && (regAddr == `PISR_ADDR_LOW_HI);
    assign wrLowLo = regWrite && (regAddr == `PISR_ADDR_LOW_LO);
    assign wrHighHi = regWrite && (regAddr == `PISR_ADDR_HIGH_HI);
    assign wrHighLo = regWrite && (regAddr == `PISR_ADDR_HIGH_LO);
    assign wrFlags = regWrite && (regAddr == `PISR_ADDR_FLAGS);
    assign wrMod = regWrite && (regAddr == `PISR_ADDR_MOD);
    // ****************************************
    // Threshold detection
    // ****************************************
    assign beyond[`PISR_BIT_ABOVE] = proxResult > highThr_q;
    assign beyond[`PISR_BIT_BELOW] = proxResult < lowThr_q;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : gStreak
            pisr_streak uStreak (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .measStrobe(measStrobe),
                .beyond(beyond[gi]),
                .countSel(irqCtrl_q[`PISR_CTRL_CNT_MSB:`PISR_CTRL_CNT_LSB]),
                .hit(limitHit[gi])
            );
        end
    endgenerate
    // ****************************************
    // Sticky status flags
    // ****************************************
    assign limitIrqEnable = irqCtrl_q[`PISR_CTRL_LIMIT_EN];
    assign readyIrqEnable = irqCtrl_q[`PISR_CTRL_READY_EN];
    assign readySet = measStrobe && readyIrqEnable;
    assign belowSet = limitHit[`PISR_BIT_BELOW] && limitIrqEnable;
    assign aboveSet = limitHit[`PISR_BIT_ABOVE] && limitIrqEnable;
    // Bit positions come from the map so the set logic and the read-back cannot drift apart.
    always @* begin
        setMask = 8'h00;
        setMask[`PISR_BIT_READY] = readySet;
        setMask[`PISR_BIT_BELOW] = belowSet;
        setMask[`PISR_BIT_ABOVE] = aboveSet;
    end
    assign clearMask = wrFlags ? regWdata : 8'h00;
    always @* begin
        // A new event beats a clear in the same cycle so no event is lost.
        flags_d = ((flags_q & ~clearMask) | setMask) & `PISR_FLAG_MASK;
    end
    // ****************************************
    // Status flag storage
    // ****************************************
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= `PISR_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end
    // ****************************************
    // Control, threshold and timing storage
    // ****************************************
    // Control bits 0, 2 and 4 are kept for read-back only and steer nothing here.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irqCtrl_q <= `PISR_RST_CTRL;
        end else begin
            if (wrCtrl) begin
                irqCtrl_q <= regWdata;
            end
        end
    end
    // The bytes land one at a time, so the compare briefly works on a half-written threshold.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lowThr_q <= `PISR_RST_THR;
        end else begin
            if (wrLowHi) begin
                lowThr_q[15:8] <= regWdata;
            end
            if (wrLowLo) begin
                lowThr_q[7:0] <= regWdata;
            end
        end
    end
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            highThr_q <= `PISR_RST_THR;
        end else begin
            if (wrHighHi) begin
                highThr_q[15:8] <= regWdata;
            end
            if (wrHighLo) begin
                highThr_q[7:0] <= regWdata;
            end
        end
    end
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            modTiming_q <= `PISR_RST_MOD;
        end else begin
            if (wrMod) begin
                modTiming_q <= regWdata;
            end
        end
    end
    // ****************************************
    // Read path
    // ****************************************
    always @* begin
        case (regAddr)
            `PISR_ADDR_IRQ_CTRL: readMux = irqCtrl_q;
            `PISR_ADDR_LOW_HI: readMux = lowThr_q[15:8];
            `PISR_ADDR_LOW_LO: readMux = lowThr_q[7:0];
            `PISR_ADDR_HIGH_HI: readMux = highThr_q[15:8];
            `PISR_ADDR_HIGH_LO: readMux = highThr_q[7:0];
            `PISR_ADDR_FLAGS: readMux = flags_q;
            `PISR_ADDR_MOD: readMux = modTiming_q;
            // The ambient level is not offered, so the reserved slot reads as zero.
            `PISR_ADDR_AMBIENT: readMux = 8'h00;
            default: readMux = 8'h00;
        endcase
    end
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= readMux;
        end
    end
    // ****************************************
    // Modulator fields
    // ****************************************
    // Every code of every field is passed on as stored; nothing here refuses a setting.
    assign modDelay = modTiming_q[`PISR_MOD_DELAY_MSB:`PISR_MOD_DELAY_LSB];
    assign modFreq = modTiming_q[`PISR_MOD_FREQ_MSB:`PISR_MOD_FREQ_LSB];
    assign modDeadTime = modTiming_q[`PISR_MOD_DEAD_MSB:`PISR_MOD_DEAD_LSB];
    // ****************************************
    // Interrupt pin
    // ****************************************
    // Open drain: the pin is only ever pulled low, never driven high.
    // The enable has a flop of its own so the OR of the flags cannot glitch the pad.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pinLow_q <= |`PISR_RST_FLAGS;
        end else begin
            pinLow_q <= |flags_d;
        end
    end
    assign intPinOut = 1'b0;
    assign intPinOe = pinLow_q;
    assign intPinIn = ~pinLow_q;
endmodule // pisr_regs

// ---- dv/pisr_regs_assertions.sv ----
/* Port checker for the status and timing bank.
   Assumes one clock domain and binding onto pisr_regs. */
`timescale 1ns/1ps
module pisr_regs_chk (
    input wire clk_sys,
    input wire sys_rst,
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire measStrobe,
    input wire [15:0] proxResult,
    input wire intPinIn,
    input wire intPinOut,
    input wire intPinOe,
    input wire [2:0] modDelay,
    input wire [1:0] modFreq,
    input wire [2:0] modDeadTime
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire fW = regWrite && regAddr == 8'h8e;
    wire mW = regWrite && regAddr == 8'h8f;
    wire [7:0] modV = {modDelay, modFreq, modDeadTime};
    pin_level_a: assert property (intPinOut == 1'b0 && intPinIn == !intPinOe)
        else $error("pin level wrong");
    sticky_flag_a: assert property (intPinOe && !fW |=> intPinOe)
        else $error("flag dropped");
    clear_all_a: assert property (fW && regWdata == 8'h0b && !measStrobe |=> !intPinOe)
        else $error("clear failed");
    no_cause_a: assert property (!intPinOe && !measStrobe |=> !intPinOe)
        else $error("flag without cause");
    flag_read_a: assert property (regAddr == 8'h8e && !regWrite && !measStrobe |=>
        (|(regRdata & 8'h0b)) == intPinOe && (regRdata & 8'hf4) == 8'h00)
        else $error("status read wrong");
    mod_read_a: assert property (regAddr == 8'h8f && !mW |=> regRdata == modV)
        else $error("timing read wrong");
    mod_hold_a: assert property (!mW |=> $stable(modV))
        else $error("timing changed");
    mod_write_a: assert property (mW |=> modV == $past(regWdata))
        else $error("timing write lost");
    cover property (measStrobe ##1 intPinOe);
    cover property (fW && intPinOe ##1 !intPinOe);
    cover property (mW);
endmodule // pisr_regs_chk
bind pisr_regs pisr_regs_chk chk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .regWrite(regWrite),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .measStrobe(measStrobe),
    .proxResult(proxResult),
    .intPinIn(intPinIn),
    .intPinOut(intPinOut),
    .intPinOe(intPinOe),
    .modDelay(modDelay),
    .modFreq(modFreq),
    .modDeadTime(modDeadTime)
);

// ---- dv/pisr_host.sv ----
/* Host model of the register port.
   Assumes the bank's clock and its registered read data. */
`timescale 1ns/1ps
module pisr_host (
    input wire clk_sys,
    output reg regWrite,
    output reg [7:0] regAddr,
    output reg [7:0] regWdata,
    input wire [7:0] regRdata
);
    initial begin
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    // A write to the ambient location goes out with regWrite held low, so the request is dropped.
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        regWrite <= (a != 8'h90);
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWdata <= ~d;
        #1;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        @(posedge clk_sys);
        #1 d = regRdata;
    endtask
    task tune;
        wr(8'h8f, 8'h01);
    endtask
endmodule // pisr_host

// ---- dv/prox_irq_status_and_modulator_regs_bench.sv ----
/* Self-checking bench for the status and timing bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module prox_irq_status_and_modulator_regs_bench;
    reg clk_sys, sys_rst, measStrobe;
    reg [15:0] proxResult;
    reg [7:0] v;
    wire regWrite, intPinIn, intPinOut, intPinOe;
    wire [7:0] regAddr, regWdata, regRdata;
    wire [2:0] modDelay, modDeadTime;
    wire [1:0] modFreq;
    integer miscompares = 0, checkCount = 0, i;
    pisr_host host (.clk_sys(clk_sys), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata));
    pisr_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .measStrobe(measStrobe), .proxResult(proxResult),
        .intPinIn(intPinIn), .intPinOut(intPinOut), .intPinOe(intPinOe), .modDelay(modDelay),
        .modFreq(modFreq), .modDeadTime(modDeadTime));
    task endOfTest;
        if (miscompares == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task meas(input [15:0] r);
        @(posedge clk_sys);
        measStrobe <= 1'b1;
        proxResult <= r;
        @(posedge clk_sys);
        measStrobe <= 1'b0;
        proxResult <= ~r;
        #1;
    endtask
    task look(input [7:0] a, input [7:0] e);
        host.rd(a, v);
        `CHK(v, e)
    endtask
    task testReset;
        look(8'h8f, 8'h01);
        `CHK({modDelay, modFreq, modDeadTime}, 8'h01)
        look(8'h8e, 8'h00);
        look(8'h95, 8'h00);
    endtask
    task testMod;
        for (i = 0; i < 4; i++) begin
            host.wr(8'h8f, {3'h7, i[1:0], 3'h2});
            `CHK({modDelay, modFreq, modDeadTime}, {3'h7, i[1:0], 3'h2})
        end
        host.tune;
        look(8'h8f, 8'h01);
    endtask
    task testHigh;
        host.wr(8'h89, 8'h22);
        host.wr(8'h8c, 8'h00);
        host.wr(8'h8d, 8'h10);
        meas(16'h0020);
        `CHK(intPinOe, 1'b0)
        meas(16'h0020);
        `CHK(intPinOe, 1'b1)
        meas(16'h0005);
        look(8'h8e, 8'h01);
        host.wr(8'h8e, 8'h00);
        look(8'h8e, 8'h01);
        host.wr(8'h8e, 8'h01);
        `CHK(intPinIn, 1'b1)
    endtask
    task testLow;
        host.wr(8'h8c, 8'hff);
        host.wr(8'h8d, 8'hff);
        host.wr(8'h8a, 8'h01);
        host.wr(8'h8b, 8'h00);
        host.wr(8'h89, 8'h02);
        meas(16'h00ff);
        look(8'h8e, 8'h02);
        host.wr(8'h89, 8'h0a);
        meas(16'h00ff);
        look(8'h8e, 8'h0a);
        host.wr(8'h8e, 8'h02);
        look(8'h8e, 8'h08);
        host.wr(8'h89, 8'h08);
        host.wr(8'h8e, 8'h08);
        meas(16'h0000);
        look(8'h8e, 8'h08);
        host.wr(8'h8e, 8'h08);
        `CHK(intPinOe, 1'b0)
    endtask
    task testStreak;
        host.wr(8'h8a, 8'h00);
        host.wr(8'h8b, 8'h00);
        host.wr(8'h8c, 8'h00);
        host.wr(8'h8d, 8'h10);
        host.wr(8'h89, 8'he2);
        for (i = 0; i < 127; i++) begin
            meas(16'h0020);
        end
        `CHK(intPinOe, 1'b0)
        meas(16'h0020);
        look(8'h8e, 8'h01);
        host.wr(8'h8e, 8'h0b);
        `CHK(intPinOe, 1'b0)
        host.wr(8'h89, 8'h42);
        for (i = 0; i < 7; i++) begin
            meas((i == 3) ? 16'h0010 : 16'h0020);
        end
        `CHK(intPinOe, 1'b0)
        meas(16'h0020);
        `CHK(intPinOe, 1'b1)
        host.wr(8'h8e, 8'h0b);
        `CHK(intPinIn, 1'b1)
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // The watchdog span is ten times the expected run, so slow scenarios still finish.
    initial begin
        #40000;
        miscompares++;
        endOfTest;
    end
    initial begin
        sys_rst = 1'b1;
        measStrobe = 1'b0;
        proxResult = 16'h0000;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        testReset;
        testMod;
        testHigh;
        testLow;
        testStreak;
        endOfTest;
    end
endmodule // prox_irq_status_and_modulator_regs_bench
